// ==== rtl/plg_lock_detect.sv ====
// Lock detector, mode indicators and break-guarded event flag
`include "plg_regs.svh"
module plg_lock_detect
  import plg_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Control bits
  input  wire logic pll_on,
  input  wire logic auto_bw,
  input  wire logic manual_track,
  input  wire logic irq_enable,
  // Software clear of the event flag
  input  wire logic event_clear,
  // Break state from system integration
  input  wire logic in_break,
  input  wire logic break_clear_enable,
  // Loop pulses, one cycle each
  input  wire logic ref_tick,
  input  wire logic fb_tick,
  // Status
  output logic      tracking_mode_flag,
  output logic      lock_flag,
  output logic      pll_event_flag,
  output logic      pll_irq
);
  plg_mode_e state_r;
  plg_mode_e state_nxt;
  plg_len_t  win_len;
  plg_cnt_t  win_err;
  logic      win_done;
  logic      run;
  logic      lock_nxt;
  logic      lock_chg;
  logic      clear_ok;

  // Tracking and lock share the longer window and the tracking indication
  function automatic logic plg_in_track(input plg_mode_e mode);
    return (mode == PLG_TRK) || (mode == PLG_LOCK);
  endfunction

  assign run = pll_on && auto_bw;

  // Lock window only once tracking; acquisition uses the shorter one
  assign win_len = plg_in_track(state_r) ? `PLG_LOCK_CYCLES : `PLG_ACQ_CYCLES;

  plg_window_meter i_plg_window_meter (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .restart  (!run),
    .win_len  (win_len),
    .ref_tick (ref_tick),
    .fb_tick  (fb_tick),
    .win_done (win_done),
    .win_err  (win_err)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PLG_OFF:
      begin
        if (run)
        begin
          state_nxt = PLG_ACQ;
        end
      end
      PLG_ACQ:
      begin
        if (win_done && win_err < `PLG_TRK_TOL)
        begin
          state_nxt = PLG_TRK;
        end
      end
      PLG_TRK:
      begin
        if (win_done && win_err < `PLG_LOCK_TOL)
        begin
          state_nxt = PLG_LOCK;
        end
        else if (win_done && win_err >= `PLG_TRK_TOL)
        begin
          state_nxt = PLG_ACQ;
        end
      end
      PLG_LOCK:
      begin
        if (win_done && win_err >= `PLG_TRK_TOL)
        begin
          state_nxt = PLG_ACQ;
        end
        else if (win_done && win_err >= `PLG_LOCK_TOL)
        begin
          state_nxt = PLG_TRK;
        end
      end
      default:
      begin
        state_nxt = PLG_OFF;
      end
    endcase
    if (!run)
    begin
      state_nxt = PLG_OFF;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= PLG_OFF;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Manual mode hands the tracking bit to software; no lock indication
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tracking_mode_flag <= 1'b0;
    end
    else if (auto_bw)
    begin
      tracking_mode_flag <= plg_in_track(state_nxt);
    end
    else
    begin
      tracking_mode_flag <= manual_track;
    end
  end

  assign lock_nxt = auto_bw && (state_nxt == PLG_LOCK);
  assign lock_chg = auto_bw && (lock_nxt != lock_flag);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_flag <= 1'b0;
    end
    else
    begin
      lock_flag <= lock_nxt;
    end
  end

  // Debugger accesses in break must not eat a pending event unless allowed
  assign clear_ok = event_clear && (!in_break || break_clear_enable);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pll_event_flag <= 1'b0;
    end
    else if (!auto_bw)
    begin
      pll_event_flag <= 1'b0;
    end
    else if (lock_chg)
    begin
      pll_event_flag <= 1'b1;
    end
    else if (clear_ok)
    begin
      pll_event_flag <= 1'b0;
    end
  end

  assign pll_irq = pll_event_flag && irq_enable;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_good_acq;
    state_r == PLG_ACQ && win_done && win_err < `PLG_TRK_TOL && run;
  endsequence

  sequence s_good_trk;
    state_r == PLG_TRK && win_done && win_err < `PLG_LOCK_TOL && run;
  endsequence

  a_clear_in_break : assert property (
    clear_ok && in_break && !lock_chg |=> !pll_event_flag)
    else $error("allowed break clear ignored");

  a_clear_stays : assert property (
    !pll_event_flag && !lock_chg ##1 $fell(in_break) |-> !pll_event_flag)
    else $error("flag restored on break exit");

  a_break_guard : assert property (
    in_break && !break_clear_enable && pll_event_flag && auto_bw |=> pll_event_flag)
    else $error("event flag lost in break");

  a_track_entry : assert property (
    (auto_bw and s_good_acq) |=> tracking_mode_flag ##1 state_r != PLG_ACQ || !run)
    else $error("tracking not entered");

  a_lock_entry : assert property (
    (auto_bw and s_good_trk) |=> lock_flag && pll_event_flag)
    else $error("lock not entered");

  a_acq_window : assert property (
    $rose(state_r == PLG_TRK) && $past(state_r) == PLG_ACQ |-> $past(win_done))
    else $error("acquisition left off window end");

  a_lock_window : assert property (
    $rose(lock_flag) |-> $past(win_done) && $past(win_len) == `PLG_LOCK_CYCLES)
    else $error("lock set off window end");

  a_bad_window : assert property (
    state_r == PLG_ACQ && win_done && win_err >= `PLG_TRK_TOL && run
    |=> state_r == PLG_ACQ)
    else $error("bad window advanced mode");

  a_manual_nolock : assert property (
    !auto_bw |=> !lock_flag && !pll_event_flag)
    else $error("lock flag set in manual mode");

  a_lock_event : assert property (
    auto_bw && $changed(lock_flag) |-> pll_event_flag ##0 (pll_irq == irq_enable))
    else $error("lock change without event");
endmodule // plg_lock_detect

// ==== rtl/plg_regs.svh ====
// Constants of the lock detector and break guard
// Overview of operation
// - Break with enable set: clears act normally
// - Flag cleared in break stays cleared
// - Enable at 0: break accesses keep event flag
// - Auto mode: tracking flag on track tolerance
// - Auto mode: lock flag on lock tolerance
// - Acquisition checked over fixed cycle window
// - Lock checked over second fixed window
// - Window average outside tolerance: no advance
// - Lock flag reads 0 without auto mode
// - Auto mode: lock change sets event flag, maybe interrupt
`ifndef PLG_REGS_SVH
`define PLG_REGS_SVH
`define PLG_ACQ_CYCLES 8'h20
`define PLG_LOCK_CYCLES 8'h80
`define PLG_TRK_TOL 9'h002
`define PLG_LOCK_TOL 9'h001
`define PLG_CNT_ZERO 9'h000
`define PLG_CNT_MAX 9'h1FF
`define PLG_REF_ONE 8'h01
`define PLG_REF_ZERO 8'h00
`define PLG_FB_ONE 9'h001
`endif

// ==== rtl/plg_pkg.sv ====
// Types shared by the lock detector files
package plg_pkg;
  typedef enum logic [1:0] {
    PLG_OFF  = 2'h0,
    PLG_ACQ  = 2'h1,
    PLG_TRK  = 2'h3,
    PLG_LOCK = 2'h2
  } plg_mode_e;
  typedef logic [7:0] plg_len_t;
  typedef logic [8:0] plg_cnt_t;
endpackage

// ==== rtl/plg_window_meter.sv ====
// Frequency error meter over a window of divided-reference cycles
`include "plg_regs.svh"
module plg_window_meter
  import plg_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     arst_n,
  // Measurement control
  input  wire logic     restart,
  input  wire plg_len_t win_len,
  input  wire logic     ref_tick,
  input  wire logic     fb_tick,
  // Result
  output logic          win_done,
  output plg_cnt_t      win_err
);
  plg_len_t ref_cnt_r;
  plg_cnt_t fb_cnt_r;
  plg_cnt_t fb_now;
  plg_cnt_t len_ext;
  logic     last_ref;

  always_comb
  begin
    fb_now = fb_cnt_r;
    if (fb_tick && fb_cnt_r != `PLG_CNT_MAX)
    begin
      fb_now = fb_cnt_r + `PLG_FB_ONE;
    end
  end

  assign len_ext  = {1'b0, win_len};
  assign last_ref = ref_tick && (ref_cnt_r == win_len - `PLG_REF_ONE);

  // Average over the whole window: total feedback edges vs reference edges
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_cnt_r <= `PLG_REF_ZERO;
      fb_cnt_r  <= `PLG_CNT_ZERO;
    end
    else if (restart)
    begin
      ref_cnt_r <= `PLG_REF_ZERO;
      fb_cnt_r  <= `PLG_CNT_ZERO;
    end
    else if (last_ref)
    begin
      ref_cnt_r <= `PLG_REF_ZERO;
      fb_cnt_r  <= `PLG_CNT_ZERO;
    end
    else
    begin
      if (ref_tick)
      begin
        ref_cnt_r <= ref_cnt_r + `PLG_REF_ONE;
      end
      fb_cnt_r <= fb_now;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_done <= 1'b0;
      win_err  <= `PLG_CNT_ZERO;
    end
    else
    begin
      win_done <= last_ref && !restart;
      if (last_ref && !restart)
      begin
        win_err <= (fb_now >= len_ext) ? fb_now - len_ext : len_ext - fb_now;
      end
    end
  end

  a_meter_restart : assert property (@(posedge core_clk) disable iff (!arst_n)
    restart |=> ref_cnt_r == `PLG_REF_ZERO && fb_cnt_r == `PLG_CNT_ZERO)
    else $error("meter not restarted");
endmodule // plg_window_meter

// ==== verif/pll_lock_detect_break_guard_tb_top.sv ====
// Self-checking bench for the lock detector and break-guarded event flag
module pll_lock_detect_break_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import plg_pkg::*;

  logic core_clk;
  logic arst_n;
  logic pll_on;
  logic auto_bw;
  logic manual_track;
  logic irq_enable;
  logic event_clear;
  logic in_break;
  logic break_clear_enable;
  logic ref_tick;
  logic fb_tick;
  logic tracking_mode_flag;
  logic lock_flag;
  logic pll_event_flag;
  logic pll_irq;
  int   n_errors;
  int   comparisons;
  int   cycles;

  plg_lock_detect i_plg_lock_detect (
    .core_clk           (core_clk),
    .arst_n             (arst_n),
    .pll_on             (pll_on),
    .auto_bw            (auto_bw),
    .manual_track       (manual_track),
    .irq_enable         (irq_enable),
    .event_clear        (event_clear),
    .in_break           (in_break),
    .break_clear_enable (break_clear_enable),
    .ref_tick           (ref_tick),
    .fb_tick            (fb_tick),
    .tracking_mode_flag (tracking_mode_flag),
    .lock_flag          (lock_flag),
    .pll_event_flag     (pll_event_flag),
    .pll_irq            (pll_irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Ticks every other cycle; the first miss ticks lack a feedback edge
  task automatic feed(input int n, input int miss);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      ref_tick <= 1'b1;
      fb_tick  <= (i >= miss);
      @(posedge core_clk);
      ref_tick <= 1'b0;
      fb_tick  <= 1'b0;
    end
  endtask

  // Flags settle two cycles after the last tick of a window
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic clr(input logic brk, input logic bce);
    @(posedge core_clk);
    in_break           <= brk;
    break_clear_enable <= bce;
    event_clear        <= 1'b1;
    @(posedge core_clk);
    event_clear <= 1'b0;
    #1;
  endtask

  task automatic mode(input logic trk, input logic lck);
    chk("tracking_mode_flag", tracking_mode_flag, trk);
    chk("lock_flag", lock_flag, lck);
  endtask

  // Hang guard, well above the roughly 1550 cycles the sequence needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    arst_n = 1'b0;
    pll_on = 1'b0;
    auto_bw = 1'b0;
    manual_track = 1'b0;
    irq_enable = 1'b0;
    event_clear = 1'b0;
    in_break = 1'b0;
    break_clear_enable = 1'b0;
    ref_tick = 1'b0;
    fb_tick = 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    settle();
    mode(1'b0, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b0);
    // Manual mode: software bit drives tracking, no lock indication
    @(posedge core_clk);
    pll_on       <= 1'b1;
    manual_track <= 1'b1;
    feed(32, 0);
    settle();
    mode(1'b1, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b0);
    @(posedge core_clk);
    auto_bw      <= 1'b1;
    manual_track <= 1'b0;
    irq_enable   <= 1'b1;
    feed(31, 0);
    settle();
    mode(1'b0, 1'b0);
    feed(1, 0);
    settle();
    mode(1'b1, 1'b0);
    feed(127, 0);
    settle();
    mode(1'b1, 1'b0);
    feed(1, 0);
    settle();
    mode(1'b1, 1'b1);
    chk("pll_event_flag", pll_event_flag, 1'b1);
    chk("pll_irq", pll_irq, 1'b1);
    clr(1'b1, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b1);
    clr(1'b1, 1'b1);
    chk("pll_event_flag", pll_event_flag, 1'b0);
    @(posedge core_clk);
    in_break <= 1'b0;
    settle();
    chk("pll_event_flag", pll_event_flag, 1'b0);
    // Window average two edges off drops lock back to acquisition
    feed(128, 2);
    settle();
    mode(1'b0, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b1);
    // One edge off passes the tracking check but never the lock check
    feed(32, 1);
    settle();
    mode(1'b1, 1'b0);
    feed(128, 1);
    settle();
    mode(1'b1, 1'b0);
    // Power cycle mid-window must start a fresh acquisition window
    feed(100, 0);
    @(posedge core_clk);
    pll_on <= 1'b0;
    settle();
    @(posedge core_clk);
    pll_on <= 1'b1;
    feed(31, 0);
    settle();
    mode(1'b0, 1'b0);
    feed(1, 0);
    settle();
    mode(1'b1, 1'b0);
    // Plain clear, then a lock change beats a clear in its own cycle
    clr(1'b0, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b0);
    @(posedge core_clk);
    irq_enable <= 1'b0;
    feed(128, 0);
    event_clear <= 1'b1;
    @(posedge core_clk);
    event_clear <= 1'b0;
    settle();
    mode(1'b1, 1'b1);
    chk("pll_event_flag", pll_event_flag, 1'b1);
    chk("pll_irq", pll_irq, 1'b0);
    // Leaving auto mode drops lock and the event flag
    @(posedge core_clk);
    auto_bw <= 1'b0;
    settle();
    mode(1'b0, 1'b0);
    chk("pll_event_flag", pll_event_flag, 1'b0);
    finish_test();
  end
endmodule // pll_lock_detect_break_guard_tb_top
